// [rtl/pcr_pkg.sv]
// Package for the peripheral configuration register bank
package pcr_pkg;
   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [15:0] PCR_BANK_BASE        = 16'hfff0;
   localparam logic [15:0] PCR_ADDR_CLOCK_SEL   = 16'hfff0;
   localparam logic [15:0] PCR_ADDR_RSVD_A      = 16'hfff1;
   localparam logic [15:0] PCR_ADDR_REFRESH     = 16'hfff2;
   localparam logic [15:0] PCR_ADDR_RSVD_B      = 16'hfff3;
   localparam logic [15:0] PCR_ADDR_BOUNDARIES  = 16'hfff4;
   localparam logic [15:0] PCR_ADDR_CPU_WAIT    = 16'hfff5;
   localparam logic [15:0] PCR_ADDR_DMA_WAIT    = 16'hfff6;
   localparam logic [15:0] PCR_ADDR_RSVD_C      = 16'hfff7;
   localparam logic [15:0] PCR_ADDR_SERIAL_LOW  = 16'hfff8;
   localparam logic [15:0] PCR_ADDR_TIMER_LOW   = 16'hfff9;
   localparam logic [15:0] PCR_ADDR_INTR_LOW    = 16'hfffa;
   localparam logic [15:0] PCR_ADDR_DMA_LOW     = 16'hfffb;
   localparam logic [15:0] PCR_ADDR_BASE_HIGH   = 16'hfffc;
   localparam logic [15:0] PCR_ADDR_ENABLES     = 16'hfffd;
   localparam logic [15:0] PCR_ADDR_PIN_CONN    = 16'hfffe;
   localparam logic [15:0] PCR_ADDR_RSVD_D      = 16'hffff;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PCR_PIN_SERIAL_LO   = 0;
   localparam int PCR_PIN_SERIAL_HI   = 1;
   localparam int PCR_PIN_IRQ_SW_LSB  = 2;
   localparam int PCR_EN_DMA_BIT      = 0;
   localparam int PCR_EN_INTR_BIT     = 1;
   localparam int PCR_EN_TIMER_BIT    = 2;
   localparam int PCR_EN_SERIAL_BIT   = 3;
   localparam int PCR_REFRESH_EN_BIT  = 7;
   localparam int PCR_CLK_CHOICE0_BIT = 2;
   localparam int PCR_CLK_CHOICE1_BIT = 3;
   localparam int PCR_CLK_CHOICE2_BIT = 4;
   localparam int PCR_CLK_PRESC_LSB   = 0;
   localparam int PCR_WAIT_FIELD_W    = 2;
   localparam int PCR_BND_LOWER_LSB   = 0;
   localparam int PCR_BND_UPPER_LSB   = 4;
   localparam int PCR_BND_FIELD_W     = 3;

   // ----------------------------------------
   // Reset values and defined-bit masks
   // ----------------------------------------
   localparam logic [7:0] PCR_RST_PIN_CONN   = 8'h00;
   localparam logic [7:0] PCR_RST_ENABLES    = 8'h00;
   localparam logic [7:0] PCR_RST_DMA_WAIT   = 8'h0f;
   localparam logic [7:0] PCR_RST_CPU_WAIT   = 8'hff;
   localparam logic [7:0] PCR_RST_REFRESH    = 8'h08;
   localparam logic [7:0] PCR_RST_CLOCK_SEL  = 8'h00;
   localparam logic [7:0] PCR_RST_OTHER      = 8'h00;
   localparam logic [7:0] PCR_MASK_PIN_CONN  = 8'h0f;
   localparam logic [7:0] PCR_MASK_ENABLES   = 8'h0f;
   localparam logic [7:0] PCR_MASK_DMA_WAIT  = 8'h0f;
   localparam logic [7:0] PCR_MASK_REFRESH   = 8'h9f;
   localparam logic [7:0] PCR_MASK_CLOCK_SEL = 8'h1f;
   localparam logic [7:0] PCR_MASK_FULL      = 8'hff;
   localparam logic [7:0] PCR_MASK_NONE      = 8'h00;
   // Divisor for prescale code 0, doubled for each code step up to 3
   localparam logic [7:0] PCR_PRESCALE_BASE  = 8'h02;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      PCR_REGION_LOWER  = 2'b00,
      PCR_REGION_MIDDLE = 2'b01,
      PCR_REGION_UPPER  = 2'b10
   } pcr_region_e;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pcr_io_req_s;

   typedef struct packed {
      logic dma_unit;
      logic interrupt_unit;
      logic timer_unit;
      logic serial_unit;
   } pcr_unit_hit_s;
endpackage : pcr_pkg

// [rtl/pcr_prescaler.sv]
// Prescaler for the counter internal clock
`timescale 1ns/10ps
module pcr_prescaler
   import pcr_pkg::*;
#(
   parameter int CNT_W = 8
) (
   mclk,
   rstn,
   prescale_field,
   tick
);
   input  wire logic       mclk;
   input  wire logic       rstn;
   input  wire logic [1:0] prescale_field;
   output      logic       tick;

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] limit;

   // Divisor two shifted by the code
   assign limit = CNT_W'((PCR_PRESCALE_BASE << prescale_field) - 8'h01);

   // ----------------------------------------
   // Divider
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         count_q <= '0;
      end else if (count_q >= limit) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tick <= 1'b0;
      end else begin
         tick <= (count_q >= limit);
      end
   end
endmodule : pcr_prescaler

// [rtl/pcr_config_regs.sv]
// Peripheral configuration register bank at the top of I/O space
`timescale 1ns/10ps
module pcr_config_regs
   import pcr_pkg::*;
(
   mclk,
   rstn,
   por_n,
   io_req,
   io_rdata,
   io_rvalid,
   io_hit,
   mem_addr,
   mem_valid,
   unit_hit,
   unit_enabled,
   mem_wait_states,
   io_wait_states,
   dma_wait_cfg,
   mem_region,
   irq_switch,
   serial_pins_on,
   refresh_enable,
   refresh_cfg,
   external_timer_clock,
   counter_clk_en
);
   input  wire logic          mclk;
   input  wire logic          rstn;
   input  wire logic          por_n;
   input  wire pcr_io_req_s   io_req;
   output      logic [7:0]    io_rdata;
   output      logic          io_rvalid;
   output      logic          io_hit;
   input  wire logic [19:0]   mem_addr;
   input  wire logic          mem_valid;
   output      pcr_unit_hit_s unit_hit;
   output      pcr_unit_hit_s unit_enabled;
   output      logic [1:0]    mem_wait_states;
   output      logic [1:0]    io_wait_states;
   output      logic [3:0]    dma_wait_cfg;
   output      pcr_region_e   mem_region;
   output      logic [1:0]    irq_switch;
   output      logic          serial_pins_on;
   output      logic          refresh_enable;
   output      logic [4:0]    refresh_cfg;
   input  wire logic          external_timer_clock;
   output      logic [2:0]    counter_clk_en;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0] regs_q [16];
   logic       refresh_en_q;
   logic [3:0] idx;
   logic       sel;
   logic       wr_hit;
   logic       prescale_tick;
   logic       ext_clk_q;
   logic       ext_tick;
   logic [7:0] pin_conn;
   logic [7:0] enables;
   logic [7:0] cpu_wait;
   logic [7:0] boundaries;
   logic [7:0] clk_sel;
   logic [7:0] base_high;
   logic [7:0] dma_low;
   logic [7:0] intr_low;
   logic [7:0] timer_low;
   logic [7:0] serial_low;
   logic       rst_any;
   logic       wr_refresh;
   logic [7:0] rdata_d;
   logic       lower_hit;
   logic       upper_hit;

   // Mask of defined bits per register
   function automatic logic [7:0] defined_mask(input logic [3:0] i);
      logic [15:0] a;
      a = PCR_BANK_BASE | {12'h000, i};
      unique case (a)
         PCR_ADDR_PIN_CONN:   defined_mask = PCR_MASK_PIN_CONN;
         PCR_ADDR_ENABLES:    defined_mask = PCR_MASK_ENABLES;
         PCR_ADDR_DMA_WAIT:   defined_mask = PCR_MASK_DMA_WAIT;
         PCR_ADDR_REFRESH:    defined_mask = PCR_MASK_REFRESH;
         PCR_ADDR_CLOCK_SEL:  defined_mask = PCR_MASK_CLOCK_SEL;
         PCR_ADDR_RSVD_A,
         PCR_ADDR_RSVD_B,
         PCR_ADDR_RSVD_C,
         PCR_ADDR_RSVD_D:     defined_mask = PCR_MASK_NONE;
         default:             defined_mask = PCR_MASK_FULL;
      endcase
   endfunction : defined_mask

   // Reset value per register
   function automatic logic [7:0] reset_value(input logic [3:0] i);
      logic [15:0] a;
      a = PCR_BANK_BASE | {12'h000, i};
      unique case (a)
         PCR_ADDR_PIN_CONN:   reset_value = PCR_RST_PIN_CONN;
         PCR_ADDR_ENABLES:    reset_value = PCR_RST_ENABLES;
         PCR_ADDR_DMA_WAIT:   reset_value = PCR_RST_DMA_WAIT;
         PCR_ADDR_CPU_WAIT:   reset_value = PCR_RST_CPU_WAIT;
         PCR_ADDR_REFRESH:    reset_value = PCR_RST_REFRESH;
         PCR_ADDR_CLOCK_SEL:  reset_value = PCR_RST_CLOCK_SEL;
         default:             reset_value = PCR_RST_OTHER;
      endcase
   endfunction : reset_value

   // Unit base match: high byte plus low byte
   function automatic logic base_match(input logic [15:0] a, input logic [7:0] hi,
                                       input logic [7:0] lo);
      base_match = (a[15:8] == hi) && (a[7:0] == lo);
   endfunction : base_match

   // Counter source: external edge when chosen, else prescaled tick
   function automatic logic pick_source(input logic ext_chosen, input logic ext_t,
                                        input logic int_t);
      pick_source = ext_chosen ? ext_t : int_t;
   endfunction : pick_source

   // Region test: top address bits below a boundary field
   function automatic logic below_field(input logic [2:0] top, input logic [2:0] fld);
      below_field = (top < fld);
   endfunction : below_field

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // top sixteen ports
   assign sel    = (io_req.addr[15:4] == PCR_BANK_BASE[15:4]);
   assign idx    = io_req.addr[3:0];
   assign io_hit = sel && (io_req.rd || io_req.wr);
   assign wr_hit = sel && io_req.wr;

   // ----------------------------------------
   // Reset and strobes
   // ----------------------------------------
   // Power-on also does all that the external reset does
   assign rst_any    = !rstn || !por_n;
   // Held off during external reset like every other write
   assign wr_refresh = rstn && wr_hit && (io_req.addr == PCR_ADDR_REFRESH);

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // defaults on every reset
   always_ff @(posedge mclk) begin
      if (rst_any) begin
         for (int i = 0; i < 16; i++) begin
            regs_q[i] <= reset_value(4'(i));
         end
      end else if (wr_hit) begin
         regs_q[idx] <= io_req.wdata & defined_mask(idx);
      end
   end

   always_ff @(posedge mclk) begin
      if (!por_n) begin
         refresh_en_q <= PCR_RST_REFRESH[PCR_REFRESH_EN_BIT];
      end else if (wr_refresh) begin
         refresh_en_q <= io_req.wdata[PCR_REFRESH_EN_BIT];
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // read back defined bits
   always_comb begin
      rdata_d = regs_q[idx];
      if (io_req.addr == PCR_ADDR_REFRESH) begin
         rdata_d = {refresh_en_q, regs_q[idx][6:0]};
      end
   end

   // Data holds until the next bank read
   always_ff @(posedge mclk) begin
      if (rst_any) begin
         io_rdata <= 8'h00;
      end else if (sel && io_req.rd) begin
         io_rdata <= rdata_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst_any) begin
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= sel && io_req.rd;
      end
   end

   // ----------------------------------------
   // Field views
   // ----------------------------------------
   assign pin_conn   = regs_q[PCR_ADDR_PIN_CONN[3:0]];
   assign enables    = regs_q[PCR_ADDR_ENABLES[3:0]];
   assign cpu_wait   = regs_q[PCR_ADDR_CPU_WAIT[3:0]];
   assign boundaries = regs_q[PCR_ADDR_BOUNDARIES[3:0]];
   assign clk_sel    = regs_q[PCR_ADDR_CLOCK_SEL[3:0]];
   assign base_high  = regs_q[PCR_ADDR_BASE_HIGH[3:0]];
   assign dma_low    = regs_q[PCR_ADDR_DMA_LOW[3:0]];
   assign intr_low   = regs_q[PCR_ADDR_INTR_LOW[3:0]];
   assign timer_low  = regs_q[PCR_ADDR_TIMER_LOW[3:0]];
   assign serial_low = regs_q[PCR_ADDR_SERIAL_LOW[3:0]];

   assign irq_switch     = pin_conn[PCR_PIN_IRQ_SW_LSB +: 2];
   // serial pins when 0 then 1
   assign serial_pins_on = !pin_conn[PCR_PIN_SERIAL_LO] && pin_conn[PCR_PIN_SERIAL_HI];

   assign unit_enabled.dma_unit       = enables[PCR_EN_DMA_BIT];
   assign unit_enabled.interrupt_unit = enables[PCR_EN_INTR_BIT];
   assign unit_enabled.timer_unit     = enables[PCR_EN_TIMER_BIT];
   assign unit_enabled.serial_unit    = enables[PCR_EN_SERIAL_BIT] && serial_pins_on;

   always_comb begin
      unit_hit = '0;
      if (io_req.rd || io_req.wr) begin
         unit_hit.dma_unit = unit_enabled.dma_unit &&
            base_match(io_req.addr, base_high, dma_low);
         unit_hit.interrupt_unit = unit_enabled.interrupt_unit &&
            base_match(io_req.addr, base_high, intr_low);
         unit_hit.timer_unit = unit_enabled.timer_unit &&
            base_match(io_req.addr, base_high, timer_low);
         unit_hit.serial_unit = unit_enabled.serial_unit &&
            base_match(io_req.addr, base_high, serial_low);
      end
   end

   // ----------------------------------------
   // Wait-state regions
   // ----------------------------------------
   // lower, middle and upper regions
   // Upper field counts down from the top of memory
   assign lower_hit = below_field(mem_addr[19:17],
                                  boundaries[PCR_BND_LOWER_LSB +: PCR_BND_FIELD_W]);
   assign upper_hit = below_field(~mem_addr[19:17],
                                  boundaries[PCR_BND_UPPER_LSB +: PCR_BND_FIELD_W]);

   always_comb begin
      mem_region = PCR_REGION_MIDDLE;
      if (lower_hit) begin
         mem_region = PCR_REGION_LOWER;
      end else if (upper_hit) begin
         mem_region = PCR_REGION_UPPER;
      end
   end

   always_comb begin
      mem_wait_states = 2'b00;
      if (mem_valid) begin
         unique case (mem_region)
            PCR_REGION_LOWER:  mem_wait_states = cpu_wait[0 +: PCR_WAIT_FIELD_W];
            PCR_REGION_MIDDLE: mem_wait_states = cpu_wait[2 +: PCR_WAIT_FIELD_W];
            PCR_REGION_UPPER:  mem_wait_states = cpu_wait[4 +: PCR_WAIT_FIELD_W];
            default:           mem_wait_states = cpu_wait[2 +: PCR_WAIT_FIELD_W];
         endcase
      end
   end
   assign io_wait_states = cpu_wait[6 +: PCR_WAIT_FIELD_W];
   assign dma_wait_cfg   = regs_q[PCR_ADDR_DMA_WAIT[3:0]][3:0];

   assign refresh_enable = refresh_en_q;
   assign refresh_cfg    = regs_q[PCR_ADDR_REFRESH[3:0]][4:0];

   // ----------------------------------------
   // Counter clocks
   // ----------------------------------------
   // prescaled internal source
   pcr_prescaler #(
      .CNT_W          (8)
   ) u_prescaler (
      .mclk           (mclk),
      .rstn           (!rst_any),
      .prescale_field (clk_sel[PCR_CLK_PRESC_LSB +: 2]),
      .tick           (prescale_tick)
   );

   // Rising edge of external clock
   always_ff @(posedge mclk) begin
      if (rst_any) begin
         ext_clk_q <= 1'b0;
      end else begin
         ext_clk_q <= external_timer_clock;
      end
   end
   assign ext_tick = external_timer_clock && !ext_clk_q;

   assign counter_clk_en[0] = pick_source(clk_sel[PCR_CLK_CHOICE0_BIT], ext_tick, prescale_tick);
   assign counter_clk_en[1] = pick_source(clk_sel[PCR_CLK_CHOICE1_BIT], ext_tick, prescale_tick);
   assign counter_clk_en[2] = pick_source(clk_sel[PCR_CLK_CHOICE2_BIT], ext_tick, prescale_tick);
endmodule : pcr_config_regs

// [tb/pcr_config_regs_props.sv]
// Checker for the configuration register bank
`timescale 1ns/10ps
module pcr_props
   import pcr_pkg::*;
(
   input wire logic          mclk,
   input wire logic          rstn,
   input wire logic          por_n,
   input wire pcr_io_req_s   io_req,
   input wire logic [7:0]    io_rdata,
   input wire logic          io_rvalid,
   input wire logic          io_hit,
   input wire pcr_unit_hit_s unit_hit,
   input wire pcr_unit_hit_s unit_enabled,
   input wire logic          mem_valid,
   input wire logic [1:0]    mem_wait_states,
   input wire logic [1:0]    io_wait_states,
   input wire logic [3:0]    dma_wait_cfg,
   input wire logic [1:0]    irq_switch,
   input wire logic          serial_pins_on,
   input wire logic          refresh_enable,
   input wire logic [4:0]    refresh_cfg
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic bank;
   logic wr_pin;
   assign bank   = io_req.addr[15:4] == 12'hfff;
   assign wr_pin = io_req.wr && io_req.addr == PCR_ADDR_PIN_CONN;
   // -------------------------------------
   // Assertions
   // -------------------------------------
   AST_READ_ANSWER: assert property (io_req.rd && bank |=> io_rvalid)
      else $error("read not answered");
   AST_NO_STRAY: assert property (!(io_req.rd && bank) |=> !io_rvalid)
      else $error("stray read answer");
   AST_BANK_HIT: assert property (io_hit == (bank && (io_req.rd || io_req.wr)))
      else $error("bank hit flag wrong");
   AST_READ_PIN: assert property (io_req.rd && io_req.addr == PCR_ADDR_PIN_CONN
      |=> io_rdata[3:2] == irq_switch && io_rdata[7:4] == 4'h0)
      else $error("pin register read wrong");
   AST_IRQ_ROUTE: assert property (wr_pin |=> irq_switch == $past(io_req.wdata[3:2]))
      else $error("interrupt switch not updated");
   AST_SERIAL_PINS: assert property (wr_pin
      |=> serial_pins_on == ($past(io_req.wdata[1]) && !$past(io_req.wdata[0])))
      else $error("serial pin use wrong");
   AST_UNIT_GATED: assert property ((unit_hit & ~unit_enabled) == 4'h0)
      else $error("disabled unit decoded");
   AST_IO_WAIT: assert property (io_req.wr && io_req.addr == PCR_ADDR_CPU_WAIT
      |=> io_wait_states == $past(io_req.wdata[7:6]))
      else $error("io wait field wrong");
   AST_WAIT_IDLE: assert property (!mem_valid |-> mem_wait_states == 2'b00)
      else $error("wait states without memory cycle");
   AST_RESET_VALUES: assert property ($rose(rstn) |-> io_wait_states == 2'b11
      && dma_wait_cfg == 4'hf && refresh_cfg == 5'h08 && irq_switch == 2'b00)
      else $error("reset defaults wrong");
   AST_POR_CLEARS: assert property (!por_n |=> !refresh_enable)
      else $error("refresh enable survives power-on reset");
   AST_REFRESH_KEPT: assert property (disable iff (!por_n) !rstn
      |=> refresh_enable == $past(refresh_enable))
      else $error("refresh enable changed by external reset");
   cover property (io_rvalid);
   cover property (!por_n);
   cover property (unit_hit.dma_unit);
endmodule : pcr_props

bind pcr_config_regs pcr_props pcr_props_inst (.mclk(mclk), .rstn(rstn), .por_n(por_n),
   .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_hit(io_hit),
   .unit_hit(unit_hit),
   .unit_enabled(unit_enabled), .mem_valid(mem_valid), .mem_wait_states(mem_wait_states),
   .io_wait_states(io_wait_states), .dma_wait_cfg(dma_wait_cfg), .irq_switch(irq_switch),
   .serial_pins_on(serial_pins_on), .refresh_enable(refresh_enable),
   .refresh_cfg(refresh_cfg));

// [tb/pcr_cpu_model.sv]
// Processor core model issuing I/O cycles to the bank
`timescale 1ns/10ps
module pcr_cpu_model
   import pcr_pkg::*;
(
   input  wire logic  mclk,
   output pcr_io_req_s io_req
);
   initial io_req = '0;
   // One request per edge, back to back allowed
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      io_req <= '{rd: !w, wr: w, addr: a, wdata: d};
   endtask : io
   // Released bus shows the inverse of the last cycle
   task automatic idle();
      @(posedge mclk);
      io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~io_req.addr, wdata: ~io_req.wdata};
   endtask : idle
endmodule : pcr_cpu_model

// [tb/pcr_config_regs_tb.sv]
// Testbench for the configuration register bank
`timescale 1ns/10ps
module pcr_config_regs_tb
   import pcr_pkg::*;
;
   logic          mclk = 1'b0;
   logic          rstn = 1'b0;
   logic          por_n = 1'b0;
   logic [19:0]   mem_addr = 20'h0_0000;
   logic          mem_valid = 1'b0;
   logic          external_timer_clock = 1'b0;
   pcr_io_req_s   io_req;
   logic [7:0]    io_rdata;
   logic          io_rvalid;
   pcr_unit_hit_s unit_hit;
   pcr_unit_hit_s unit_enabled;
   logic [1:0]    mem_wait_states;
   logic [1:0]    io_wait_states;
   logic [3:0]    dma_wait_cfg;
   pcr_region_e   mem_region;
   logic [1:0]    irq_switch;
   logic          serial_pins_on;
   logic          refresh_enable;
   logic [4:0]    refresh_cfg;
   logic [2:0]    counter_clk_en;
   logic [7:0]    exp_q[$];
   logic [7:0]    v[16];
   logic [7:0]    h;
   logic [2:0]    top3[3] = '{3'd0, 3'd3, 3'd7};
   int            errors = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   int            seed = 35;

   always #4 mclk = ~mclk;

   pcr_cpu_model pcr_cpu_model_inst (.mclk, .io_req);
   pcr_config_regs pcr_config_regs_inst (.mclk, .rstn, .por_n, .io_req, .io_rdata,
      .io_rvalid, .io_hit(), .mem_addr, .mem_valid, .unit_hit, .unit_enabled,
      .mem_wait_states, .io_wait_states, .dma_wait_cfg, .mem_region, .irq_switch,
      .serial_pins_on, .refresh_enable, .refresh_cfg, .external_timer_clock,
      .counter_clk_en);

   // -------------------------------------
   // Checking and closing
   // -------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      if (errors == 0 && cmp_count > 0 && exp_q.size() == 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge mclk) begin
      if (io_rvalid === 1'b1) begin
         chk(io_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
      end
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         report_and_stop();
      end
   end

   // -------------------------------------
   // Stimulus
   // -------------------------------------
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      pcr_cpu_model_inst.io(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      pcr_cpu_model_inst.io(1'b0, a, 8'h00);
      exp_q.push_back(e);
   endtask : rd

   function automatic logic [7:0] mask(input logic [3:0] n);
      case (n)
         4'h0: mask = 8'h1f;
         4'h2: mask = 8'h9f;
         4'h6, 4'hd, 4'he: mask = 8'h0f;
         4'h1, 4'h3, 4'h7, 4'hf: mask = 8'h00;
         default: mask = 8'hff;
      endcase
   endfunction : mask

   function automatic logic [7:0] dflt(input logic [3:0] n);
      case (n)
         4'h2: dflt = 8'h08;
         4'h5: dflt = 8'hff;
         4'h6: dflt = 8'h0f;
         default: dflt = 8'h00;
      endcase
   endfunction : dflt

   task automatic pulse_rst(input logic por);
      pcr_cpu_model_inst.idle();
      @(posedge mclk);
      if (por) por_n <= 1'b0;
      else rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn  <= 1'b1;
      por_n <= 1'b1;
      @(posedge mclk);
      #1;
   endtask : pulse_rst

   // Ticks over a 40 cycle window, three external rising edges early on
   task automatic ticks(input logic [7:0] cs, input int b, input logic [7:0] n_exp);
      int n;
      n = 0;
      wr(PCR_ADDR_CLOCK_SEL, cs);
      pcr_cpu_model_inst.idle();
      for (int k = 0; k < 40; k++) begin
         @(posedge mclk);
         external_timer_clock <= (k % 10 >= 4) && (k % 10 < 8) && (k < 30);
         #1;
         n += int'(counter_clk_en[b]);
      end
      chk(8'(n), n_exp);
   endtask : ticks

   initial begin
      repeat (4) @(posedge mclk);
      rstn  <= 1'b1;
      por_n <= 1'b1;
      for (int i = 0; i < 16; i++) rd(16'hfff0 | 16'(i), dflt(4'(i)));
      for (int i = 0; i < 16; i++) begin
         v[i] = 8'($random(seed));
         wr(16'hfff0 | 16'(i), v[i]);
      end
      for (int i = 0; i < 16; i++) rd(16'hfff0 | 16'(i), v[i] & mask(4'(i)));
      wr(PCR_ADDR_REFRESH, 8'h80);
      pulse_rst(1'b0);
      chk(8'(refresh_enable), 8'h01);
      rd(PCR_ADDR_REFRESH, 8'h88);
      rd(PCR_ADDR_CPU_WAIT, 8'hff);
      pulse_rst(1'b1);
      chk(8'(refresh_enable), 8'h00);
      for (int i = 0; i < 16; i++) begin
         wr(PCR_ADDR_PIN_CONN, 8'(i));
         pcr_cpu_model_inst.idle();
         #1;
         chk(8'(irq_switch), 8'(i[3:2]));
         chk(8'(serial_pins_on), 8'(i[1] & ~i[0]));
      end
      h = 8'($random(seed));
      wr(PCR_ADDR_PIN_CONN, 8'h02);
      wr(PCR_ADDR_BASE_HIGH, h);
      for (int u = 0; u < 4; u++) wr(PCR_ADDR_DMA_LOW - 16'(u), 8'(16 * u + 8));
      for (int u = 0; u < 4; u++) begin
         for (int k = 0; k < 2; k++) begin
            wr(PCR_ADDR_ENABLES, k == 1 ? 8'h0f : 8'h0f ^ (8'h01 << u));
            pcr_cpu_model_inst.io(1'b0, {h, 8'(16 * u + 8)}, 8'h00);
            #1;
            chk(8'(unit_hit), k == 1 ? 8'h08 >> u : 8'h00);
         end
      end
      wr(PCR_ADDR_BOUNDARIES, 8'h33);
      wr(PCR_ADDR_CPU_WAIT, 8'he4);
      for (int i = 0; i < 3; i++) begin
         pcr_cpu_model_inst.idle();
         mem_addr  <= {top3[i], 17'h0_0000};
         mem_valid <= 1'b1;
         @(posedge mclk);
         #1;
         chk(8'(mem_region), 8'(i));
         chk(8'(mem_wait_states), 8'(i));
      end
      chk(8'(io_wait_states), 8'h03);
      mem_valid <= 1'b0;
      ticks(8'h04, 0, 8'd3);
      ticks(8'h04, 1, 8'd20);
      ticks(8'h00, 2, 8'd20);
      ticks(8'h01, 0, 8'd10);
      wr(PCR_ADDR_REFRESH, 8'h80);
      wr(PCR_ADDR_REFRESH, 8'h00);
      pcr_cpu_model_inst.idle();
      #1;
      chk(8'(refresh_enable), 8'h00);
      repeat (4) @(posedge mclk);
      report_and_stop();
   end
endmodule : pcr_config_regs_tb
